// *** hdl/cfl_pkg.sv ***
package cfl_pkg;

  localparam int CLK_MHZ = 100;
  localparam int WAKE_WAIT_US = 30;
  localparam int WAKE_WAIT_CYC = WAKE_WAIT_US * CLK_MHZ;
  localparam int FLASH_MAX_MHZ = 20;
  localparam int SCLK_HALF_CYC =
    (CLK_MHZ + 2 * FLASH_MAX_MHZ - 1) / (2 * FLASH_MAX_MHZ);

  localparam logic [7:0] WAKE_OPCODE = 8'hab;
  localparam logic [7:0] READ_OPCODE = 8'h0b;
  localparam logic [23:0] START_ADDR = 24'h000000;
  localparam logic [5:0] WAKE_BITS = 6'h08;
  localparam logic [5:0] CMD_BITS = 6'h20;
  localparam logic [5:0] DUMMY_CLOCKS = 6'h08;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [2:0] ACTIVE_MAX_WIDTH = 3'h2;
  localparam logic [2:0] PASSIVE_MAX_WIDTH = 3'h5;
  localparam logic [3:0] OE_COMMAND = 4'hd;
  localparam logic [3:0] OE_DATA_X2 = 4'hc;
  localparam logic [3:0] OE_NONE = 4'h0;

  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_PASSIVE,
    MODE_JTAG,
    MODE_FACTORY
  } cfl_mode_type;

  // Bits taken per transfer for a width code of x1 up to x32.
  function automatic logic [5:0] cfl_nbits(input logic [2:0] w);
    unique case (w)
      3'h0: cfl_nbits = 6'h01;
      3'h1: cfl_nbits = 6'h02;
      3'h2: cfl_nbits = 6'h04;
      3'h3: cfl_nbits = 6'h08;
      3'h4: cfl_nbits = 6'h10;
      default: cfl_nbits = 6'h20;
    endcase
  endfunction : cfl_nbits

  // Shifts one transfer into a word, first bits ending up most significant.
  function automatic logic [31:0] cfl_pack(input logic [31:0] word,
                                           input logic [31:0] data,
                                           input logic [2:0] w);
    unique case (w)
      3'h0: cfl_pack = {word[30:0], data[0]};
      3'h1: cfl_pack = {word[29:0], data[1:0]};
      3'h2: cfl_pack = {word[27:0], data[3:0]};
      3'h3: cfl_pack = {word[23:0], data[7:0]};
      3'h4: cfl_pack = {word[15:0], data[15:0]};
      default: cfl_pack = data;
    endcase
  endfunction : cfl_pack

endpackage : cfl_pkg

// *** hdl/cfl_fifo.sv ***
`timescale 1ns/10ps
module cfl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] count;
  } cfl_fifo_type;

  cfl_fifo_type r_reg;
  cfl_fifo_type r_next;
  logic push;
  logic pop;

  assign in_ready = r_reg.count != (AW+1)'(DEPTH);
  assign out_valid = r_reg.count != '0;
  assign out_data = r_reg.mem[r_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    r_next = r_reg;
    if (push)
    begin
      r_next.mem[r_reg.wr] = in_data;
      r_next.wr = (r_reg.wr == AW'(DEPTH - 1)) ? '0 : r_reg.wr + 1'b1;
    end
    if (pop)
      r_next.rd = (r_reg.rd == AW'(DEPTH - 1)) ? '0 : r_reg.rd + 1'b1;
    if (push && !pop)
      r_next.count = r_reg.count + 1'b1;
    else if (pop && !push)
      r_next.count = r_reg.count - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end
endmodule : cfl_fifo

// *** hdl/cfl_loader.sv ***
// Function
// - Rising restart edge starts the load.
// - Signal user mode only after full load.
// - Active, passive and JTAG loading methods.
// - Active mode clocks flash from internal clock.
// - First flash transaction is wake-up instruction.
// - Wait thirty microseconds after wake-up.
// - Fast-read from address zero, sequential data.
// - Active x1/x2/x4, passive up to x32, JTAG x1.
// - JTAG port loads configuration memory.
// - Factory mask memory replaces external flash.
// - Wide modes turn data-out line bidirectional.
`timescale 1ns/10ps
module cfl_loader
  import cfl_pkg::*;
#(
  parameter logic [23:0] LOAD_WORDS = 24'h000400,
  parameter int FIFO_DEPTH = 8
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Restart and mode straps
  input wire logic config_restart_n,
  input wire logic [1:0] cfg_mode_pins,
  input wire logic [2:0] cfg_width_pins,
  // Serial flash
  output logic flash_sclk,
  output logic flash_cs_n,
  input wire logic [3:0] flash_io_in,
  output logic [3:0] flash_io_out,
  output logic [3:0] flash_io_oe,
  // Passive link
  input wire logic pcfg_clk,
  input wire logic pcfg_cs_n,
  input wire logic [31:0] pcfg_data,
  // JTAG loading
  input wire logic jtag_tck,
  input wire logic jtag_tdi,
  input wire logic jtag_cfg_en,
  // Factory mask memory
  output logic [23:0] mask_mem_addr,
  input wire logic [31:0] mask_mem_data,
  // Configuration memory cells
  output logic [31:0] mem_cells_data,
  output logic mem_cells_valid,
  input wire logic mem_cells_ready,
  // Status
  output logic config_done,
  output logic config_error
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_WAKE,
    ST_GAP,
    ST_CMD,
    ST_DUMMY,
    ST_DATA,
    ST_PASS,
    ST_JTAG,
    ST_ROM,
    ST_FLUSH,
    ST_DONE
  } cfl_state_type;

  typedef struct packed {
    cfl_state_type state;
    cfl_mode_type mode;
    logic [2:0] width;
    logic [3:0] div;
    logic sclk;
    logic cs_n;
    logic [3:0] io_oe;
    logic [31:0] shreg;
    logic [5:0] bitcnt;
    logic [11:0] wait_cnt;
    logic [31:0] word;
    logic [5:0] fill;
    logic word_valid;
    logic [23:0] words;
    logic [23:0] rom_addr;
    logic rom_pend;
    logic done;
    logic error;
    logic [2:0] rst_sync;
    logic [4:0] strap_s1;
    logic [4:0] strap_s2;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
    logic [2:0] tck_sync;
    logic [1:0] tdi_sync;
    logic [1:0] jen_sync;
    logic [2:0] tog_sync;
  } cfl_sys_type;

  typedef struct packed {
    logic [1:0] rst_s;
    logic [2:0] w_s1;
    logic [2:0] w_s2;
    logic [31:0] shift;
    logic [5:0] fill;
    logic [31:0] word;
    logic tog;
  } cfl_link_type;

  cfl_sys_type r_reg;
  cfl_sys_type r_next;
  cfl_link_type l_reg;
  cfl_link_type l_next;
  logic fifo_in_ready;

  cfl_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .reset_n(reset_n),
    .in_data(r_reg.word),
    .in_valid(r_reg.word_valid),
    .in_ready(fifo_in_ready),
    .out_data(mem_cells_data),
    .out_valid(mem_cells_valid),
    .out_ready(mem_cells_ready)
  );

  assign flash_sclk = r_reg.sclk;
  assign flash_cs_n = r_reg.cs_n;
  assign flash_io_oe = r_reg.io_oe;
  // Write protect and hold stay inactive high whenever they are driven.
  assign flash_io_out = {2'b11, 1'b0, r_reg.shreg[31]};
  assign mask_mem_addr = r_reg.rom_addr;
  assign config_done = r_reg.done;
  assign config_error = r_reg.error;

  // Passive link logic runs on the master's clock.
  always_comb
  begin
    l_next = l_reg;
    l_next.rst_s = {l_reg.rst_s[0], reset_n};
    l_next.w_s1 = r_reg.width;
    l_next.w_s2 = l_reg.w_s1;
    if (!l_reg.rst_s[1])
    begin
      l_next.shift = '0;
      l_next.fill = '0;
      l_next.word = '0;
      l_next.tog = 1'b0;
    end
    else if (pcfg_cs_n)
      l_next.fill = '0;
    else
    begin
      l_next.shift = cfl_pack(l_reg.shift, pcfg_data, l_reg.w_s2);
      l_next.fill = l_reg.fill + cfl_nbits(l_reg.w_s2);
      if (l_next.fill == WORD_BITS)
      begin
        l_next.fill = '0;
        l_next.word = l_next.shift;
        l_next.tog = ~l_reg.tog;
      end
    end
  end

  always_ff @(posedge pcfg_clk)
  begin
    l_reg <= l_next;
  end

  always_comb
  begin
    logic rise;
    logic tick;
    logic take;
    logic [31:0] din;
    logic [2:0] dw;
    rise = r_reg.rst_sync[1] & ~r_reg.rst_sync[2];
    tick = r_reg.div == 4'(SCLK_HALF_CYC - 1);
    take = 1'b0;
    din = '0;
    dw = r_reg.width;
    r_next = r_reg;
    r_next.rst_sync = {r_reg.rst_sync[1:0], config_restart_n};
    r_next.strap_s1 = {cfg_mode_pins, cfg_width_pins};
    r_next.strap_s2 = r_reg.strap_s1;
    r_next.io_s1 = flash_io_in;
    r_next.io_s2 = r_reg.io_s1;
    r_next.tck_sync = {r_reg.tck_sync[1:0], jtag_tck};
    r_next.tdi_sync = {r_reg.tdi_sync[0], jtag_tdi};
    r_next.jen_sync = {r_reg.jen_sync[0], jtag_cfg_en};
    r_next.tog_sync = {r_reg.tog_sync[1:0], l_reg.tog};
    if (r_reg.word_valid && fifo_in_ready)
      r_next.word_valid = 1'b0;

    unique case (r_reg.state)
      ST_IDLE, ST_DONE:
      begin
      end
      ST_WAKE, ST_CMD, ST_DUMMY, ST_DATA:
      begin
        // A word that the FIFO cannot take holds the flash clock.
        if (!(r_reg.state == ST_DATA && r_reg.word_valid && !fifo_in_ready))
        begin
          r_next.div = tick ? '0 : r_reg.div + 1'b1;
          if (tick)
          begin
            r_next.sclk = ~r_reg.sclk;
            if (!r_reg.sclk)
            begin
              if (r_reg.bitcnt != '0)
                r_next.bitcnt = r_reg.bitcnt - 1'b1;
              if (r_reg.state == ST_DATA)
              begin
                take = 1'b1;
                din = (r_reg.width == 3'h0) ?
                  {31'h0, r_reg.io_s2[1]} : {28'h0, r_reg.io_s2};
              end
            end
            else
            begin
              r_next.shreg = {r_reg.shreg[30:0], 1'b0};
              if (r_reg.state == ST_DATA)
              begin
                if (r_reg.words == LOAD_WORDS)
                begin
                  r_next.cs_n = 1'b1;
                  r_next.io_oe = OE_NONE;
                  r_next.state = ST_FLUSH;
                end
              end
              else if (r_reg.bitcnt == '0)
              begin
                unique case (r_reg.state)
                  ST_WAKE:
                  begin
                    r_next.cs_n = 1'b1;
                    r_next.wait_cnt = 12'(WAKE_WAIT_CYC - 1);
                    r_next.state = ST_GAP;
                  end
                  ST_CMD:
                  begin
                    r_next.bitcnt = DUMMY_CLOCKS;
                    if (r_reg.width == 3'h1)
                      r_next.io_oe = OE_DATA_X2;
                    else if (r_reg.width == 3'h2)
                      r_next.io_oe = OE_NONE;
                    r_next.state = ST_DUMMY;
                  end
                  default:
                    r_next.state = ST_DATA;
                endcase
              end
            end
          end
        end
      end
      ST_GAP:
      begin
        if (r_reg.wait_cnt == '0)
        begin
          r_next.cs_n = 1'b0;
          r_next.div = '0;
          r_next.shreg = {READ_OPCODE, START_ADDR};
          r_next.bitcnt = CMD_BITS;
          r_next.state = ST_CMD;
        end
        else
          r_next.wait_cnt = r_reg.wait_cnt - 1'b1;
      end
      ST_PASS:
      begin
        if (r_reg.tog_sync[1] ^ r_reg.tog_sync[2])
        begin
          if (r_reg.word_valid)
            r_next.error = 1'b1;
          else
          begin
            r_next.word = l_reg.word;
            r_next.word_valid = 1'b1;
            r_next.words = r_reg.words + 1'b1;
          end
        end
        if (r_reg.words == LOAD_WORDS)
          r_next.state = ST_FLUSH;
      end
      ST_JTAG:
      begin
        if (r_reg.tck_sync[1] & ~r_reg.tck_sync[2] & r_reg.jen_sync[1])
        begin
          take = 1'b1;
          din = {31'h0, r_reg.tdi_sync[1]};
          dw = 3'h0;
        end
        if (r_reg.words == LOAD_WORDS)
          r_next.state = ST_FLUSH;
      end
      ST_ROM:
      begin
        if (r_reg.rom_pend)
        begin
          r_next.word = mask_mem_data;
          r_next.word_valid = 1'b1;
          r_next.words = r_reg.words + 1'b1;
          r_next.rom_addr = r_reg.rom_addr + 1'b1;
          r_next.rom_pend = 1'b0;
        end
        else if (!r_reg.word_valid && r_reg.words != LOAD_WORDS)
          r_next.rom_pend = 1'b1;
        else if (r_reg.words == LOAD_WORDS)
          r_next.state = ST_FLUSH;
      end
      ST_FLUSH:
      begin
        if (!r_reg.word_valid && !mem_cells_valid)
        begin
          r_next.done = 1'b1;
          r_next.state = ST_DONE;
        end
      end
      default:
        r_next.state = ST_IDLE;
    endcase

    if (take)
    begin
      r_next.word = cfl_pack(r_reg.word, din, dw);
      r_next.fill = r_reg.fill + cfl_nbits(dw);
      if (r_next.fill == WORD_BITS)
      begin
        r_next.fill = '0;
        if (r_reg.word_valid)
          r_next.error = 1'b1;
        r_next.word_valid = 1'b1;
        r_next.words = r_reg.words + 1'b1;
      end
    end

    if (!r_reg.rst_sync[1])
    begin
      // Held restart leaves the device unconfigured and the flash idle.
      r_next.state = ST_IDLE;
      r_next.cs_n = 1'b1;
      r_next.sclk = 1'b0;
      r_next.io_oe = OE_NONE;
      r_next.done = 1'b0;
    end
    else if (rise)
    begin
      r_next.mode = cfl_mode_type'(r_reg.strap_s2[4:3]);
      r_next.width = r_reg.strap_s2[2:0];
      r_next.words = '0;
      r_next.fill = '0;
      r_next.word_valid = 1'b0;
      r_next.rom_addr = '0;
      r_next.rom_pend = 1'b0;
      r_next.error = 1'b0;
      r_next.done = 1'b0;
      r_next.div = '0;
      r_next.sclk = 1'b0;
      r_next.state = ST_IDLE;
      unique case (cfl_mode_type'(r_reg.strap_s2[4:3]))
        MODE_ACTIVE:
        begin
          if (r_reg.strap_s2[2:0] > ACTIVE_MAX_WIDTH)
            r_next.error = 1'b1;
          else
          begin
            r_next.cs_n = 1'b0;
            r_next.io_oe = OE_COMMAND;
            r_next.shreg = {WAKE_OPCODE, 24'h000000};
            r_next.bitcnt = WAKE_BITS;
            r_next.state = ST_WAKE;
          end
        end
        MODE_PASSIVE:
        begin
          if (r_reg.strap_s2[2:0] > PASSIVE_MAX_WIDTH)
            r_next.error = 1'b1;
          else
            r_next.state = ST_PASS;
        end
        MODE_JTAG:
          r_next.state = ST_JTAG;
        MODE_FACTORY:
          r_next.state = ST_ROM;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      r_reg <= '0;
      r_reg.cs_n <= 1'b1;
    end
    else
      r_reg <= r_next;
  end
endmodule : cfl_loader

// *** testbench/cfl_loader_monitor.sv ***
`timescale 1ns/10ps
module cfl_loader_monitor
  import cfl_pkg::*;
(
  // Clock and reset
  input logic sys_clk,
  input logic reset_n,
  // Observed pins
  input logic config_restart_n,
  input logic flash_sclk,
  input logic flash_cs_n,
  input logic [3:0] flash_io_oe,
  input logic [31:0] mem_cells_data,
  input logic mem_cells_valid,
  input logic mem_cells_ready,
  input logic config_done,
  input logic config_error
);
  logic [11:0] hi_cnt_reg;
  logic armed_reg;

  // Times the deselect gap; armed once an instruction has ended.
  always_ff @(posedge sys_clk)
  begin
    hi_cnt_reg <= (!reset_n || !flash_cs_n) ? 12'h000 :
      hi_cnt_reg + {11'h000, hi_cnt_reg != 12'hfff};
    armed_reg <= reset_n && config_restart_n &&
      (armed_reg || $rose(flash_cs_n));
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_RESTART_ABORT:
    assert property (!config_restart_n [*6] |-> flash_cs_n && !config_done)
    else $error("restart low did not stop the load");
  AST_WAKE_GAP:
    assert property ($fell(flash_cs_n) && armed_reg |-> hi_cnt_reg >= 3000)
    else $error("read started too soon after wake-up");
  AST_CMD_OE:
    assert property ($fell(flash_cs_n) |-> flash_io_oe == OE_COMMAND)
    else $error("command phase drive enables wrong");
  AST_SCLK_START:
    assert property ($fell(flash_cs_n) |-> !flash_sclk ##[1:4] flash_sclk)
    else $error("flash clock did not start after select");
  AST_SCLK_HIGH:
    assert property ($rose(flash_sclk) |=> flash_sclk ##1 flash_sclk
      ##1 !flash_sclk)
    else $error("flash clock high phase not three cycles");
  AST_IDLE_CLK:
    assert property (flash_cs_n && $past(flash_cs_n) |-> !flash_sclk)
    else $error("flash clock runs while deselected");
  AST_DONE_EMPTY:
    assert property (config_done |-> !mem_cells_valid)
    else $error("done while words still pending");
  AST_DONE_HOLD:
    assert property (config_done && config_restart_n |=> config_done)
    else $error("done dropped without restart");
  AST_STALL_HOLD:
    assert property (mem_cells_valid && !mem_cells_ready |=>
      mem_cells_valid && $stable(mem_cells_data))
    else $error("word changed while stalled");
  AST_ERR_NOLOAD:
    assert property (config_error |-> flash_cs_n)
    else $error("flash selected despite error");
endmodule : cfl_loader_monitor

bind cfl_loader cfl_loader_monitor u_mon (.sys_clk, .reset_n,
  .config_restart_n, .flash_sclk, .flash_cs_n, .flash_io_oe, .mem_cells_data,
  .mem_cells_valid, .mem_cells_ready, .config_done, .config_error);

// *** testbench/cfl_flash_model.sv ***
`timescale 1ns/10ps
module cfl_flash_model (
  // Flash pins
  input logic flash_sclk,
  input logic flash_cs_n,
  input logic [3:0] flash_io_out,
  input logic [2:0] width,
  output logic [3:0] flash_io_in
);
  logic [7:0] ops[$];
  logic [31:0] cmd, v;
  logic [23:0] addr;
  int n, d;
  realtime t_hi = 0.0, gap = 0.0;

  function automatic logic [31:0] pat(input int k);
    return 32'ha5c30f00 + k * 32'h01010013;
  endfunction : pat

  initial flash_io_in = 4'h0;
  // Deselected lines float, so show the inverse of the last value.
  always @(posedge flash_cs_n)
  begin
    t_hi = $realtime;
    flash_io_in <= ~flash_io_in;
  end
  always @(negedge flash_cs_n)
  begin
    gap = $realtime - t_hi;
    n = 0;
    d = 0;
  end
  always @(posedge flash_sclk)
  if (!flash_cs_n)
  begin
    if (n < 32)
      cmd = {cmd[30:0], flash_io_out[0]};
    n++;
    if (n == 8)
      ops.push_back(cmd[7:0]);
    if (n == 32)
      addr = cmd[23:0];
  end
  // Data leaves on falling edges after eight dummy clocks.
  always @(negedge flash_sclk)
  if (!flash_cs_n && n >= 40)
  begin
    v = pat(d / 32) << (d % 32);
    case (width)
      3'h0: flash_io_in[1] <= v[31];
      3'h1: flash_io_in[1:0] <= v[31:30];
      default: flash_io_in <= v[31:28];
    endcase
    d += 1 << width;
  end
endmodule : cfl_flash_model

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
  import cfl_pkg::*;
;
  localparam int NW = 12;
  logic sys_clk = 1'b0, reset_n = 1'b0, config_restart_n = 1'b1;
  logic [1:0] cfg_mode_pins = 2'h0;
  logic [2:0] cfg_width_pins = 3'h0;
  logic pcfg_clk = 1'b0, pcfg_cs_n = 1'b1, jtag_tck = 1'b0, jtag_tdi = 1'b0;
  logic jtag_cfg_en = 1'b0, mem_cells_ready = 1'b1, flash_sclk, flash_cs_n;
  logic config_done, config_error, mem_cells_valid;
  logic [31:0] pcfg_data = 32'h0, mask_mem_data = 32'h0, mem_cells_data;
  logic [3:0] flash_io_in, flash_io_out, flash_io_oe;
  logic [23:0] mask_mem_addr;
  logic [31:0] got[$];
  int num_errors = 0, cmp_count = 0;

  cfl_loader #(.LOAD_WORDS(24'h00000c), .FIFO_DEPTH(8)) u_dut (.sys_clk,
    .reset_n, .config_restart_n, .cfg_mode_pins, .cfg_width_pins,
    .flash_sclk, .flash_cs_n, .flash_io_in, .flash_io_out, .flash_io_oe,
    .pcfg_clk, .pcfg_cs_n, .pcfg_data, .jtag_tck, .jtag_tdi, .jtag_cfg_en,
    .mask_mem_addr, .mask_mem_data, .mem_cells_data, .mem_cells_valid,
    .mem_cells_ready, .config_done, .config_error);
  cfl_flash_model u_flash (.flash_sclk, .flash_cs_n, .flash_io_out,
    .width(cfg_width_pins), .flash_io_in);

  function automatic logic [31:0] pat(input int k);
    return 32'ha5c30f00 + k * 32'h01010013;
  endfunction : pat

  initial forever #5 sys_clk = ~sys_clk;
  // The link side resets only while its own clock ticks.
  initial repeat (3)
  begin
    #7 pcfg_clk = 1'b1;
    #7 pcfg_clk = 1'b0;
  end
  always @(posedge sys_clk)
    mask_mem_data <= pat(int'(mask_mem_addr));
  always @(posedge sys_clk)
    if (reset_n && mem_cells_valid === 1'b1 && mem_cells_ready)
      got.push_back(mem_cells_data);

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic finish_test;
    $display("Counts: errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic wait_done(input string name);
    int i;
    i = 0;
    while (config_done !== 1'b1 && i < 20000)
    begin
      @(posedge sys_clk);
      i++;
    end
    #1;
    chk({31'h0, config_done}, 32'h1);
    chk(got.size(), NW);
    foreach (got[k]) chk(got[k], pat(k));
    $display("test %s done", name);
  endtask : wait_done

  task automatic restart(input logic [1:0] m, input logic [2:0] w);
    @(posedge sys_clk);
    #1 config_restart_n = 1'b0;
    cfg_mode_pins = m;
    cfg_width_pins = w;
    repeat (8) @(posedge sys_clk);
    #1 config_restart_n = 1'b1;
    got.delete();
    u_flash.ops.delete();
  endtask : restart

  task automatic t_active_x1;
    wait_done("active_x1");
    chk(u_flash.ops[0], WAKE_OPCODE);
    chk(u_flash.ops[1], READ_OPCODE);
    chk(u_flash.addr, START_ADDR);
    chk({31'h0, u_flash.gap >= 30000.0}, 32'h1);
  endtask : t_active_x1

  task automatic t_active_wide(input logic [2:0] w);
    logic [3:0] oe_exp;
    oe_exp = (w == 3'h1) ? OE_DATA_X2 : OE_NONE;
    restart(2'h0, w);
    wait (u_flash.ops.size() == 2);
    wait (u_flash.n > 40);
    #1;
    chk({28'h0, flash_io_oe}, {28'h0, oe_exp});
    // Restart in the middle of the data phase must abort the load.
    @(posedge flash_sclk);
    restart(2'h0, w);
    chk({31'h0, flash_cs_n}, 32'h1);
    wait_done("active_wide");
    chk(u_flash.ops[0], WAKE_OPCODE);
  endtask : t_active_wide

  task automatic t_refuse;
    restart(2'h0, 3'h3);
    repeat (20) @(posedge sys_clk);
    chk({31'h0, config_error}, 32'h1);
    chk({31'h0, flash_cs_n}, 32'h1);
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_passive;
    restart(2'h1, 3'h5);
    repeat (10) @(posedge sys_clk);
    // Two idle link clocks let the link side leave reset and see the width.
    repeat (2)
    begin
      #80 pcfg_clk = 1'b1;
      #80 pcfg_clk = 1'b0;
    end
    pcfg_cs_n = 1'b0;
    for (int k = 0; k < NW; k++)
    begin
      pcfg_data = pat(k);
      #80 pcfg_clk = 1'b1;
      #80 pcfg_clk = 1'b0;
    end
    pcfg_cs_n = 1'b1;
    wait_done("passive");
  endtask : t_passive

  task automatic t_jtag;
    logic [31:0] w;
    restart(2'h2, 3'h0);
    jtag_cfg_en = 1'b1;
    for (int b = 0; b < NW * 32; b++)
    begin
      w = pat(b / 32);
      jtag_tdi = w[31 - b % 32];
      repeat (4) @(posedge sys_clk);
      #1 jtag_tck = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 jtag_tck = 1'b0;
    end
    jtag_cfg_en = 1'b0;
    wait_done("jtag");
  endtask : t_jtag

  task automatic t_factory;
    mem_cells_ready = 1'b0;
    restart(2'h3, 3'h0);
    repeat (80) @(posedge sys_clk);
    chk({31'h0, mem_cells_valid}, 32'h1);
    chk({31'h0, config_done}, 32'h0);
    #1 mem_cells_ready = 1'b1;
    wait_done("factory");
  endtask : t_factory

  initial
  begin
    repeat (5) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    t_active_x1();
    t_active_wide(3'h1);
    t_active_wide(3'h2);
    t_refuse();
    t_passive();
    t_jtag();
    t_factory();
    finish_test();
  end

  initial
  begin
    #500000;
    num_errors++;
    finish_test();
  end
endmodule : tb_top
